// *** logic/ebc_map.svh ***
// Register map, field positions and command codes of the readout control bank
// Notes on behaviour
// R01 - Enable mask has 16 bits; slot n uses master bit 2n, slave 2n+1.
// R02 - Only channels whose enable bit is one take part in data transmission; in bypass the code sends the selected channel regardless.
// R03 - Capture window counts 16-bit words; software keeps it at most 4000.
// R04 - Format 0 (default) sends three zero bytes and the event frame count.
// R05 - Event frame count is one byte, zero at event start, then increments.
// R06 - Format 1 sends a 32-bit run frame count, zeroed only at run start.
// R07 - Format 2 sends a 3-byte event time tag above the event frame count.
// R08 - Command writes launch routines on the selected or enabled channels.
// R09 - Command 0x00 selects run mode and aborts any other active command.
// R10 - Commands 0x01, 0x02, 0x03: phase, baseline or both on one channel.
// R11 - Command 0x0F bypasses suppression, raw readout of selected channel.
// R12 - Command 0x10 fully calibrates enabled channels; bits 11:8 show which.
// R13 - Commands 0x11 and 0x12 sweep only phase or only baseline calibration.
// R14 - Phase sweep: slave result overwrites the master's shared PLL phase.
// R15 - Read-only sync register shows detected, configured front-ends.
// R16 - Status bits: 0 phase run, 1 baseline run, 2 phase ok, 4 sweep, 5 done.
// R17 - Status bit 3 marks the last baseline calibration ended by watchdog.
// R18 - Status bit 6 shows raw passthrough, bit 7 shows suppression active.
// R19 - Status bits 31:16 mark calibrated channels; command 0xFF clears them.
// R20 - Processor status reads 0x80 after reset.
// R21 - Software keeps the channel selector within 0 to 15.
// R22 - Done bit clears on a new non-run command, sets when the routine ends.
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH

`define EBC_ADDR_CHAN_MASK 8'h08
`define EBC_ADDR_CAPT_LEN 8'h09
`define EBC_ADDR_FMT 8'h0A
`define EBC_ADDR_SYNC 8'h10
`define EBC_ADDR_STATUS 8'h11
`define EBC_ADDR_SELECT 8'h12
`define EBC_ADDR_CMD 8'h1F

`define EBC_RST_CHAN_MASK 16'h0000
`define EBC_RST_CAPT_LEN 16'h0000
`define EBC_RST_FMT 8'h00
`define EBC_RST_SELECT 4'h0
`define EBC_RST_CMD 8'h00

`define EBC_CMD_RUN 8'h00
`define EBC_CMD_PHASE_ONE 8'h01
`define EBC_CMD_BASE_ONE 8'h02
`define EBC_CMD_FULL_ONE 8'h03
`define EBC_CMD_BYPASS 8'h0F
`define EBC_CMD_FULL_ALL 8'h10
`define EBC_CMD_PHASE_ALL 8'h11
`define EBC_CMD_BASE_ALL 8'h12
`define EBC_CMD_RESET 8'hFF

`define EBC_FMT_SINGLE 8'h00
`define EBC_FMT_TEST 8'h01
`define EBC_FMT_MULTI 8'h02

`define EBC_CAPT_LEN_MAX 16'h0FA0
`define EBC_LAST_CH 4'hF
`endif

// *** logic/ebc_pkg.sv ***
// Types shared by the readout control bank and its frame tag unit
package ebc_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_BYPASS,
    ST_SEEK,
    ST_PHASE,
    ST_BASE,
    ST_HOLD
  } ebc_state_t;

  // Request to the calibration datapath
  typedef struct packed {
    logic start;
    logic abort;
    logic baseline;
    logic [3:0] channel;
  } ebc_cal_req_t;

  // Answer from the calibration datapath
  typedef struct packed {
    logic done;
    logic ok;
    logic watchdog;
  } ebc_cal_rsp_t;

  // Frame events from the event builder
  typedef struct packed {
    logic run_start;
    logic event_start;
    logic frame_sent;
    logic [23:0] time_tag;
  } ebc_frame_ev_t;

endpackage

// *** logic/ebc_frame_tag.sv ***
// Frame counter field generator for outgoing data frames
`timescale 1ns/1ps
`include "ebc_map.svh"
module ebc_frame_tag
  import ebc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] format,
  input wire ebc_frame_ev_t ev,
  output logic [31:0] field_r
);

  logic [7:0] event_frames_r;
  logic [31:0] run_frame_count_r;

  // R05 per-event count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_frames_r <= 8'h00;
    end else if (ev.event_start) begin
      event_frames_r <= 8'h00;
    end else if (ev.frame_sent) begin
      event_frames_r <= event_frames_r + 8'h01;
    end
  end

  // R06 run-wide count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_frame_count_r <= 32'h0000_0000;
    end else if (ev.run_start) begin
      run_frame_count_r <= 32'h0000_0000;
    end else if (ev.frame_sent) begin
      run_frame_count_r <= run_frame_count_r + 32'h0000_0001;
    end
  end

  // Unknown formats fall back to the default layout
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      field_r <= 32'h0000_0000;
    end else begin
      unique case (format)
        // R06 global count
        `EBC_FMT_TEST: field_r <= run_frame_count_r;
        // R07 time tag
        `EBC_FMT_MULTI: field_r <= {ev.time_tag, event_frames_r};
        // R04 zero upper bytes
        default: field_r <= {24'h00_0000, event_frames_r};
      endcase
    end
  end

endmodule // ebc_frame_tag

// *** logic/ebc_regs.sv ***
// Readout control bank: event builder setup and calibration sequencer
`timescale 1ns/1ps
`include "ebc_map.svh"
module ebc_regs
  import ebc_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  // Slow-control register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_r,
  output logic reg_rd_valid_r,
  // Front-end sync detectors
  input wire logic [NUM_CH-1:0] sync_detect,
  // Event builder
  input wire ebc_frame_ev_t frame_ev,
  output logic [NUM_CH-1:0] tx_channel_en_r,
  output logic [15:0] capture_len_words_r,
  output logic [31:0] frame_counter_field_r,
  output logic suppression_active,
  output logic raw_passthrough_active,
  // Calibration datapath
  output ebc_cal_req_t cal_req_r,
  input wire ebc_cal_rsp_t cal_rsp,
  output logic pll_load_r,
  output logic [2:0] pll_slot_r
);

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [15:0] channel_enable_mask_r;
  logic [15:0] capture_window_length_r;
  logic [7:0] frame_counter_format_r;
  logic [3:0] single_channel_select_r;
  logic [7:0] processor_command_r;
  logic [15:0] channel_calibrated_flags_r;
  logic phase_lock_ok_r;
  logic watchdog_hit_r;
  logic sweep_finished_r;
  logic cmd_done_r;
  logic sweep_r;
  logic do_phase_r;
  logic do_base_r;
  logic chan_ok_r;
  logic [3:0] ch_r;
  ebc_state_t st_r;

  logic [31:0] processor_status;
  logic cmd_wr;
  logic [7:0] cmd_code;

  // --------------------------------------------------------------
  // Sequencer next-state terms
  // --------------------------------------------------------------
  ebc_state_t st_nxt;
  logic [3:0] ch_nxt;
  logic go_phase;
  logic go_base;
  logic chan_end;
  logic chan_end_ok;
  logic finish;
  logic abort;
  logic proc_reset;
  logic launch;
  logic sweep_nxt;
  logic do_phase_nxt;
  logic do_base_nxt;

  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr_en && (reg_addr == a);
  endfunction

  function automatic logic busy(input ebc_state_t s);
    return (s == ST_SEEK) || (s == ST_PHASE) || (s == ST_BASE);
  endfunction

  assign cmd_wr = wr_hit(`EBC_ADDR_CMD);
  assign cmd_code = reg_wdata[7:0];

  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_enable_mask_r <= `EBC_RST_CHAN_MASK;
      capture_window_length_r <= `EBC_RST_CAPT_LEN;
      frame_counter_format_r <= `EBC_RST_FMT;
      single_channel_select_r <= `EBC_RST_SELECT;
    end else begin
      // R01 enable mask
      if (wr_hit(`EBC_ADDR_CHAN_MASK)) begin
        channel_enable_mask_r <= reg_wdata[15:0];
      end
      // R03 length in words
      if (wr_hit(`EBC_ADDR_CAPT_LEN)) begin
        capture_window_length_r <= reg_wdata[15:0];
      end
      if (wr_hit(`EBC_ADDR_FMT)) begin
        frame_counter_format_r <= reg_wdata[7:0];
      end
      // R21 selector range
      if (wr_hit(`EBC_ADDR_SELECT)) begin
        single_channel_select_r <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      processor_command_r <= `EBC_RST_CMD;
    end else if (cmd_wr) begin
      processor_command_r <= cmd_code;
    end
  end

  // --------------------------------------------------------------
  // Calibration sequencer
  // --------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ch_nxt = ch_r;
    sweep_nxt = sweep_r;
    do_phase_nxt = do_phase_r;
    do_base_nxt = do_base_r;
    go_phase = 1'b0;
    go_base = 1'b0;
    chan_end = 1'b0;
    chan_end_ok = 1'b0;
    finish = 1'b0;
    abort = 1'b0;
    proc_reset = 1'b0;
    if (cmd_wr) begin
      // R08 command launch
      unique case (cmd_code)
        // R09 run or abort
        `EBC_CMD_RUN: begin
          abort = (st_r != ST_RUN);
          st_nxt = ST_RUN;
        end
        `EBC_CMD_RESET: begin
          abort = (st_r != ST_RUN);
          proc_reset = 1'b1;
          st_nxt = ST_RUN;
        end
        // R11 raw passthrough
        `EBC_CMD_BYPASS: begin
          abort = busy(st_r);
          st_nxt = ST_BYPASS;
        end
        // R10 single channel
        `EBC_CMD_PHASE_ONE, `EBC_CMD_BASE_ONE, `EBC_CMD_FULL_ONE: begin
          abort = busy(st_r);
          sweep_nxt = 1'b0;
          do_phase_nxt = cmd_code[0];
          do_base_nxt = cmd_code[1];
          ch_nxt = single_channel_select_r;
          go_phase = cmd_code[0];
          go_base = !cmd_code[0];
          st_nxt = cmd_code[0] ? ST_PHASE : ST_BASE;
        end
        // R12 R13 sweeps start at channel 0
        `EBC_CMD_FULL_ALL, `EBC_CMD_PHASE_ALL, `EBC_CMD_BASE_ALL: begin
          abort = busy(st_r);
          sweep_nxt = 1'b1;
          do_phase_nxt = (cmd_code != `EBC_CMD_BASE_ALL);
          do_base_nxt = (cmd_code != `EBC_CMD_PHASE_ALL);
          ch_nxt = 4'h0;
          st_nxt = ST_SEEK;
        end
        default: st_nxt = st_r;
      endcase
    end else begin
      unique case (st_r)
        ST_RUN, ST_BYPASS, ST_HOLD: begin
          st_nxt = st_r;
        end
        // R02 skip disabled channels
        ST_SEEK: begin
          if (channel_enable_mask_r[ch_r]) begin
            go_phase = do_phase_r;
            go_base = !do_phase_r;
            st_nxt = do_phase_r ? ST_PHASE : ST_BASE;
          end else if (ch_r == `EBC_LAST_CH) begin
            finish = 1'b1;
          end else begin
            ch_nxt = ch_r + 4'h1;
          end
        end
        ST_PHASE: begin
          if (cal_rsp.done) begin
            if (do_base_r && cal_rsp.ok) begin
              go_base = 1'b1;
              st_nxt = ST_BASE;
            end else begin
              chan_end = 1'b1;
              chan_end_ok = cal_rsp.ok && !do_base_r;
            end
          end
        end
        ST_BASE: begin
          if (cal_rsp.done) begin
            chan_end = 1'b1;
            chan_end_ok = chan_ok_r && cal_rsp.ok && !cal_rsp.watchdog;
          end
        end
      endcase
      if (chan_end) begin
        if (sweep_r && (ch_r != `EBC_LAST_CH)) begin
          // R12 next channel in turn
          ch_nxt = ch_r + 4'h1;
          st_nxt = ST_SEEK;
        end else begin
          finish = 1'b1;
        end
      end
      if (finish) begin
        st_nxt = ST_HOLD;
      end
    end
  end

  assign launch = go_phase || go_base;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RUN;
      ch_r <= 4'h0;
      sweep_r <= 1'b0;
      do_phase_r <= 1'b0;
      do_base_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      sweep_r <= sweep_nxt;
      do_phase_r <= do_phase_nxt;
      do_base_r <= do_base_nxt;
    end
  end

  // Phase result of this channel, kept for the full-calibration verdict
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan_ok_r <= 1'b0;
    end else if (launch && !(st_r == ST_PHASE)) begin
      chan_ok_r <= 1'b1;
    end else if (st_r == ST_PHASE && cal_rsp.done) begin
      chan_ok_r <= cal_rsp.ok;
    end
  end

  // Request pulses to the calibration datapath
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_req_r <= '0;
    end else begin
      cal_req_r.start <= launch;
      cal_req_r.abort <= abort;
      cal_req_r.baseline <= go_base;
      cal_req_r.channel <= ch_nxt;
    end
  end

  // --------------------------------------------------------------
  // Shared PLL update
  // --------------------------------------------------------------
  // Ascending sweep order puts the slave after its master, so the
  // slave's phase is the one left in the slot's PLL.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pll_load_r <= 1'b0;
      pll_slot_r <= 3'h0;
    end else begin
      // R14 slave overwrites master
      pll_load_r <= (st_r == ST_PHASE) && cal_rsp.done && cal_rsp.ok;
      pll_slot_r <= ch_r[3:1];
    end
  end

  // --------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_lock_ok_r <= 1'b0;
    end else if (proc_reset) begin
      phase_lock_ok_r <= 1'b0;
    end else if (st_r == ST_PHASE && cal_rsp.done && !cmd_wr) begin
      // R16 phase verdict
      phase_lock_ok_r <= cal_rsp.ok;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_hit_r <= 1'b0;
    end else if (proc_reset) begin
      watchdog_hit_r <= 1'b0;
    end else if (st_r == ST_BASE && cal_rsp.done && !cmd_wr) begin
      // R17 last baseline run
      watchdog_hit_r <= cal_rsp.watchdog;
    end
  end

  // A finish in the same cycle as a command write cannot occur: the
  // write takes the sequencer path and suppresses the finish.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_done_r <= 1'b0;
      sweep_finished_r <= 1'b0;
    end else if (finish) begin
      // R22 done at routine end
      cmd_done_r <= 1'b1;
      sweep_finished_r <= sweep_r;
    end else if (cmd_wr && cmd_code != `EBC_CMD_RUN) begin
      // R22 cleared by new command
      cmd_done_r <= 1'b0;
      sweep_finished_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_calibrated_flags_r <= 16'h0000;
    end else if (proc_reset) begin
      // R19 cleared by reset command
      channel_calibrated_flags_r <= 16'h0000;
    end else if (chan_end) begin
      // R19 per-channel update
      channel_calibrated_flags_r[ch_r] <= chan_end_ok;
    end
  end

  // --------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------
  // R18 readout mode bits
  assign suppression_active = (st_r == ST_RUN);
  assign raw_passthrough_active = (st_r == ST_BYPASS);

  // R16 R20 status layout
  always_comb begin
    processor_status = 32'h0000_0000;
    processor_status[0] = (st_r == ST_PHASE);
    processor_status[1] = (st_r == ST_BASE);
    processor_status[2] = phase_lock_ok_r;
    processor_status[3] = watchdog_hit_r;
    processor_status[4] = sweep_finished_r;
    processor_status[5] = cmd_done_r;
    processor_status[6] = raw_passthrough_active;
    processor_status[7] = suppression_active;
    // R12 current sweep channel
    processor_status[11:8] = sweep_r ? ch_r : 4'h0;
    processor_status[31:16] = channel_calibrated_flags_r;
  end

  // --------------------------------------------------------------
  // Event builder outputs
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_channel_en_r <= '0;
      capture_len_words_r <= 16'h0000;
    end else begin
      if (st_r == ST_BYPASS) begin
        // R11 only the selected channel
        tx_channel_en_r <= NUM_CH'(1) << single_channel_select_r;
      end else begin
        // R02 enabled channels only
        tx_channel_en_r <= channel_enable_mask_r[NUM_CH-1:0];
      end
      // R03 word count to capture logic
      capture_len_words_r <= capture_window_length_r;
    end
  end

  ebc_frame_tag u_frame_tag (
    .clock(clock),
    .rst_n(rst_n),
    .format(frame_counter_format_r),
    .ev(frame_ev),
    .field_r(frame_counter_field_r)
  );

  // --------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 32'h0000_0000;
      reg_rd_valid_r <= 1'b0;
    end else begin
      reg_rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        unique case (reg_addr)
          `EBC_ADDR_CHAN_MASK:
            reg_rdata_r <= {16'h0000, channel_enable_mask_r};
          `EBC_ADDR_CAPT_LEN:
            reg_rdata_r <= {16'h0000, capture_window_length_r};
          `EBC_ADDR_FMT: reg_rdata_r <= {24'h00_0000, frame_counter_format_r};
          // R15 sync presence
          `EBC_ADDR_SYNC:
            reg_rdata_r <= {16'h0000, 16'(sync_detect)};
          `EBC_ADDR_STATUS: reg_rdata_r <= processor_status;
          `EBC_ADDR_SELECT:
            reg_rdata_r <= {28'h000_0000, single_channel_select_r};
          `EBC_ADDR_CMD: reg_rdata_r <= {24'h00_0000, processor_command_r};
          default: reg_rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // ebc_regs

// *** verif/ebc_regs_properties.sv ***
// Port assertions for the readout control bank
`timescale 1ns/1ps
`include "ebc_map.svh"
module ebc_regs_properties
  import ebc_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd_valid_r,
  input wire logic [NUM_CH-1:0] tx_channel_en_r,
  input wire logic suppression_active,
  input wire logic raw_passthrough_active,
  input wire ebc_cal_req_t cal_req_r,
  input wire ebc_cal_rsp_t cal_rsp,
  input wire logic pll_load_r,
  input wire logic [2:0] pll_slot_r
);
  logic cmd_wr;
  logic [7:0] cmd;
  assign cmd_wr = reg_wr_en && reg_addr == `EBC_ADDR_CMD;
  assign cmd = reg_wdata[7:0];
  logic base_run_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      base_run_r <= 1'b0;
    end else if (cal_req_r.start) begin
      base_run_r <= cal_req_r.baseline;
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_read_valid: assert property (
    1 |=> reg_rd_valid_r == $past(reg_rd_en)) else $error("read valid");
  chk_mode_excl: assert property (
    !(suppression_active && raw_passthrough_active)) else $error("modes");
  chk_run_abort: assert property (
    cmd_wr && cmd == `EBC_CMD_RUN && !suppression_active
    |=> cal_req_r.abort && suppression_active) else $error("abort");
  chk_bypass_entry: assert property (
    cmd_wr && cmd == `EBC_CMD_BYPASS
    |=> raw_passthrough_active && !cal_req_r.start) else $error("bypass");
  chk_phase_start: assert property (
    cmd_wr && suppression_active
    && (cmd == `EBC_CMD_PHASE_ONE || cmd == `EBC_CMD_FULL_ONE)
    |=> cal_req_r.start && !cal_req_r.baseline) else $error("phase start");
  chk_base_start: assert property (
    cmd_wr && suppression_active && cmd == `EBC_CMD_BASE_ONE
    |=> cal_req_r.start && cal_req_r.baseline) else $error("base start");
  chk_start_pulse: assert property (
    cal_req_r.start |=> !cal_req_r.start) else $error("start pulse");
  chk_run_idle: assert property (
    suppression_active |-> !cal_req_r.start) else $error("start in run");
  chk_pll_slot: assert property (
    cal_rsp.done && cal_rsp.ok && !base_run_r && !suppression_active
    |=> pll_load_r && pll_slot_r == $past(cal_req_r.channel[3:1]))
    else $error("pll load");
  chk_mask_tx: assert property (
    reg_wr_en && reg_addr == `EBC_ADDR_CHAN_MASK && suppression_active
    |-> ##2 tx_channel_en_r == $past(reg_wdata[NUM_CH-1:0], 2))
    else $error("tx mask");
endmodule // ebc_regs_properties

bind ebc_regs ebc_regs_properties #(.NUM_CH(NUM_CH)) i_ebc_regs_properties (
  .clock, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
  .reg_rd_valid_r, .tx_channel_en_r, .suppression_active,
  .raw_passthrough_active, .cal_req_r, .cal_rsp, .pll_load_r, .pll_slot_r
);

// *** verif/ebc_cal_model.sv ***
// Calibration datapath model answering start requests after a latency
`timescale 1ns/1ps
module ebc_cal_model
  import ebc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire ebc_cal_req_t req,
  input wire logic ok_cfg,
  input wire logic wd_cfg,
  input wire logic [7:0] lat_cfg,
  output ebc_cal_rsp_t rsp
);
  logic busy_r;
  logic base_r;
  logic junk_r;
  logic [7:0] cnt_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      base_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (req.start) begin
      busy_r <= 1'b1;
      base_r <= req.baseline;
      cnt_r <= lat_cfg;
    end else if (req.abort) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      busy_r <= cnt_r != 8'h00;
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // Flags toggle outside done so a design must not trust them there
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      junk_r <= 1'b0;
    end else begin
      junk_r <= !junk_r;
    end
  end
  always_comb begin
    rsp.done = busy_r && cnt_r == 8'h00;
    rsp.ok = rsp.done ? ok_cfg : junk_r;
    rsp.watchdog = rsp.done ? (wd_cfg && base_r) : !junk_r;
  end
endmodule // ebc_cal_model

// *** verif/ebc_regs_tb.sv ***
// Self-checking bench for the readout control bank
`timescale 1ns/1ps
`include "ebc_map.svh"
module ebc_regs_tb;
  import ebc_pkg::*;
  localparam logic [7:0] CMDS [5] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h03};
  logic clock, rst_n;
  logic reg_wr_en, reg_rd_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata_r;
  logic reg_rd_valid_r;
  logic [15:0] sync_detect;
  ebc_frame_ev_t frame_ev;
  logic [15:0] tx_channel_en_r, capture_len_words_r;
  logic [31:0] frame_counter_field_r;
  logic suppression_active, raw_passthrough_active;
  ebc_cal_req_t cal_req_r;
  ebc_cal_rsp_t cal_rsp;
  logic pll_load_r;
  logic [2:0] pll_slot_r;
  logic ok_cfg, wd_cfg;
  logic [7:0] lat_cfg;
  logic [31:0] rd, g;
  logic [23:0] tag;
  logic [15:0] mask;
  logic [7:0] n;
  logic [3:0] sel;
  int num_errors;
  int num_checks;
  int loads, i, e, k;

  ebc_regs #(
    .NUM_CH(16)
  ) i_ebc_regs (
    .clock, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata_r, .reg_rd_valid_r, .sync_detect, .frame_ev,
    .tx_channel_en_r, .capture_len_words_r, .frame_counter_field_r,
    .suppression_active, .raw_passthrough_active, .cal_req_r, .cal_rsp,
    .pll_load_r, .pll_slot_r
  );
  ebc_cal_model i_ebc_cal_model (
    .clock, .rst_n, .req(cal_req_r), .ok_cfg, .wd_cfg, .lat_cfg, .rsp(cal_rsp)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (pll_load_r === 1'b1) begin
      loads++;
    end
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    #1;
    rd = reg_rdata_r;
  endtask
  task automatic wait_st(input int b);
    int j;
    for (j = 0; j < 400; j++) begin
      rdr(`EBC_ADDR_STATUS);
      if (rd[b] === 1'b1) break;
    end
    if (j == 400) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic ev(input logic [2:0] p);
    @(posedge clock);
    frame_ev <= {p, tag};
    @(posedge clock);
    frame_ev <= {3'b000, tag};
    repeat (3) @(posedge clock);
    #1;
  endtask
  function automatic logic [31:0] fexp(input logic [7:0] f,
      input logic [7:0] c, input logic [31:0] gc, input logic [23:0] t);
    case (f)
      `EBC_FMT_TEST: return gc;
      `EBC_FMT_MULTI: return {t, c};
      default: return {24'h00_0000, c};
    endcase
  endfunction
  function automatic logic [6:0] sexp(input logic [7:0] c, input logic ok,
      input logic wd);
    logic wdf;
    wdf = wd && c != `EBC_CMD_PHASE_ONE;
    return {ok && !wdf, 2'b10, wdf, ok && c != `EBC_CMD_BASE_ONE, 2'b00};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    sync_detect = 16'h0000;
    frame_ev = '0;
    tag = 24'h00_0000;
    ok_cfg = 1'b1;
    wd_cfg = 1'b0;
    lat_cfg = 8'h14;
    num_errors = 0;
    num_checks = 0;
    void'($urandom(32'h3b9f_6a08));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rdr(`EBC_ADDR_STATUS);
    check(rd, 32'h0000_0080);
    rdr(`EBC_ADDR_FMT);
    check(rd, 32'h0000_0000);
    rdr(8'h05);
    check(rd, 32'h0000_0000);
    @(posedge clock);
    sync_detect <= 16'($urandom);
    wr(`EBC_ADDR_SYNC, 32'h0000_FFFF);
    rdr(`EBC_ADDR_SYNC);
    check(rd, {16'h0000, sync_detect});
    for (i = 0; i < 4; i++) begin
      mask = (i == 0) ? 16'hFFFF : 16'($urandom);
      wr(`EBC_ADDR_CHAN_MASK, {16'h0000, mask});
      rdr(`EBC_ADDR_CHAN_MASK);
      check(rd, {16'h0000, mask});
      check({16'h0000, tx_channel_en_r}, {16'h0000, mask});
    end
    wr(`EBC_ADDR_CAPT_LEN, 32'h0000_0FA0);
    rdr(`EBC_ADDR_CAPT_LEN);
    check(rd, 32'h0000_0FA0);
    check({16'h0000, capture_len_words_r}, 32'h0000_0FA0);
    // Event frame count wraps in the long second event; format 3 is unknown
    for (i = 0; i < 4; i++) begin
      wr(`EBC_ADDR_FMT, 32'(i));
      g = 32'h0000_0000;
      ev(3'b100);
      for (e = 0; e < 2; e++) begin
        tag = 24'($urandom);
        ev(3'b010);
        n = 8'h00;
        check(frame_counter_field_r, fexp(8'(i), n, g, tag));
        k = (i == 0 && e == 1) ? 257 : $urandom_range(4, 1);
        repeat (k) begin
          ev(3'b001);
          n++;
          g++;
          check(frame_counter_field_r, fexp(8'(i), n, g, tag));
        end
      end
    end
    sel = 4'($urandom);
    wr(`EBC_ADDR_SELECT, {28'h000_0000, sel});
    for (i = 0; i < 5; i++) begin
      wr(`EBC_ADDR_CMD, 32'h0000_00FF);
      rdr(`EBC_ADDR_STATUS);
      check({rd[31:16], 8'h00, rd[7:0]}, 32'h0000_0080);
      ok_cfg = i != 4;
      wd_cfg = i == 3;
      wr(`EBC_ADDR_CMD, {24'h00_0000, CMDS[i]});
      rdr(`EBC_ADDR_STATUS);
      check({rd[5], rd[1:0]}, {1'b0, CMDS[i] == 2, CMDS[i] != 2});
      wait_st(5);
      check({rd[16 + sel], rd[5:0]}, sexp(CMDS[i], ok_cfg, wd_cfg));
    end
    ok_cfg = 1'b1;
    wd_cfg = 1'b0;
    wr(`EBC_ADDR_CMD, 32'h0000_0003);
    wr(`EBC_ADDR_CMD, 32'h0000_0000);
    rdr(`EBC_ADDR_STATUS);
    check({rd[7:6], rd[1:0], suppression_active}, 5'b10001);
    wr(`EBC_ADDR_CMD, 32'h0000_000F);
    wr(`EBC_ADDR_CMD, 32'h0000_0042);
    rdr(`EBC_ADDR_STATUS);
    check(rd[7:6], 2'b01);
    check({16'h0000, tx_channel_en_r}, 32'h1 << sel);
    lat_cfg = 8'h02;
    mask = 16'($urandom) | 16'h0003;
    wr(`EBC_ADDR_CMD, 32'h0000_0000);
    wr(`EBC_ADDR_CHAN_MASK, {16'h0000, mask});
    for (i = 0; i < 3; i++) begin
      wr(`EBC_ADDR_CMD, 32'h0000_00FF);
      loads = 0;
      wr(`EBC_ADDR_CMD, 32'h0000_0010 + 32'(i));
      wait_st(4);
      check(rd[31:16], mask);
      check({rd[11:8], rd[5:4]}, 6'h3F);
      check(loads, (i == 2) ? 0 : $countones(mask));
      wr(`EBC_ADDR_CMD, 32'h0000_0000);
    end
    finish_test();
  end
endmodule // ebc_regs_tb
